// >>> hdl/cmsr_map.svh
/*
  register offsets, field positions, reset values and field codes of the
  clock monitor enable and output skew register bank.
  assumes an 8-bit register address space reached over the device's
  internal register port behind the serial control interface.
*/
`ifndef CMSR_MAP_SVH
`define CMSR_MAP_SVH

// register offsets
`define CMSR_LOSS_HIGH_ADDR    8'h8a
`define CMSR_MON_LOW_ADDR      8'h8b
`define CMSR_SKEW_ONE_ADDR     8'h8e
`define CMSR_SKEW_TWO_ADDR     8'h8f

// loss_monitor_enable_high field positions
`define CMSR_HI_LOSS_ONE_BIT   0
`define CMSR_HI_LOSS_TWO_BIT   1

// monitor_enable_low field positions
`define CMSR_LO_OFFSET_ONE_BIT 0
`define CMSR_LO_OFFSET_TWO_BIT 1
`define CMSR_LO_LOSS_ONE_BIT   4
`define CMSR_LO_LOSS_TWO_BIT   5

// reset values
`define CMSR_LOSS_HIGH_RESET   8'h03
`define CMSR_MON_LOW_RESET     8'hff
`define CMSR_SKEW_ONE_RESET    8'h00
`define CMSR_SKEW_TWO_RESET    8'h00

// reserved bits of the two monitor registers, as they read back
`define CMSR_LOSS_HIGH_RSVD    8'h00
`define CMSR_MON_LOW_RSVD      8'hcc

// loss monitor select codes
`define CMSR_LOSS_CODE_OFF     2'h0
`define CMSR_LOSS_CODE_RSVD    2'h1
`define CMSR_LOSS_CODE_SLOW    2'h2
`define CMSR_LOSS_CODE_NORMAL  2'h3

`endif

// >>> hdl/cmsr_pkg.sv
/*
  types shared by the clock monitor enable and output skew register bank.
  assumes nothing of its surroundings.
*/
package cmsr_pkg;

  // detector choice handed to one clock input's loss monitor
  typedef enum logic [2:0] {
    CMSR_LOSS_OFF    = 3'h1,
    CMSR_LOSS_SLOW   = 3'h2,
    CMSR_LOSS_NORMAL = 3'h4
  } cmsr_loss_mode_t;

  // settings seen by the input monitors and the output phase adjust
  typedef struct packed {
    cmsr_loss_mode_t    input_one_loss_mode;
    cmsr_loss_mode_t    input_two_loss_mode;
    logic               input_one_loss_code_bad;
    logic               input_two_loss_code_bad;
    logic               input_one_offset_monitor_on;
    logic               input_two_offset_monitor_on;
    logic signed [7:0]  output_one_phase_offset;
    logic signed [7:0]  output_two_phase_offset;
  } cmsr_cfg_t;

endpackage

// >>> hdl/cmsr_regs.sv
/*
  clock monitor enable and output skew register bank: four 8-bit
  registers, their read-back mux and the decoded settings for the
  clock input monitors and the output phase adjust logic.
  assumes the register port is driven by control logic on ref_clk, so
  no synchroniser is needed; the monitors themselves live elsewhere.
  the settings leave on a flop, one cycle behind the registers, so a
  consumer sees a write two edges after the write strobe; consumers
  must treat a flagged reserved loss code as monitoring switched off.
*/
`include "cmsr_map.svh"
`timescale 1ns/1ns
`default_nettype none

module cmsr_regs (
  // clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              reset_n,
  // register port
  input  wire  logic [7:0]        reg_addr,
  input  wire  logic              reg_wr_en,
  input  wire  logic [7:0]        reg_wr_data,
  input  wire  logic              reg_rd_en,
  output var   logic [7:0]        reg_rd_data_ff,
  // decoded settings
  output var   cmsr_pkg::cmsr_cfg_t cfg_ff
);

  // reset images, kept whole so that single fields can be picked from them
  localparam logic [7:0] LOSS_HIGH_RST   = `CMSR_LOSS_HIGH_RESET;
  localparam logic [7:0] MON_LOW_RST     = `CMSR_MON_LOW_RESET;
  localparam logic [7:0] SKEW_ONE_RST    = `CMSR_SKEW_ONE_RESET;
  localparam logic [7:0] SKEW_TWO_RST    = `CMSR_SKEW_TWO_RESET;

  localparam logic [1:0] LOSS_HIGH_RST_F = {
    LOSS_HIGH_RST[`CMSR_HI_LOSS_TWO_BIT],
    LOSS_HIGH_RST[`CMSR_HI_LOSS_ONE_BIT]
  };
  localparam logic [1:0] LOSS_LOW_RST_F  = {
    MON_LOW_RST[`CMSR_LO_LOSS_TWO_BIT],
    MON_LOW_RST[`CMSR_LO_LOSS_ONE_BIT]
  };
  localparam logic [1:0] OFFSET_RST_F    = {
    MON_LOW_RST[`CMSR_LO_OFFSET_TWO_BIT],
    MON_LOW_RST[`CMSR_LO_OFFSET_ONE_BIT]
  };

  // settings while reset is held: both loss selects reset to 11, the
  // normal detector, so the decoded modes start there too
  localparam cmsr_pkg::cmsr_cfg_t CFG_RST = '{
    input_one_loss_mode:         cmsr_pkg::CMSR_LOSS_NORMAL,
    input_two_loss_mode:         cmsr_pkg::CMSR_LOSS_NORMAL,
    input_one_loss_code_bad:     1'b0,
    input_two_loss_code_bad:     1'b0,
    input_one_offset_monitor_on: OFFSET_RST_F[0],
    input_two_offset_monitor_on: OFFSET_RST_F[1],
    output_one_phase_offset:     SKEW_ONE_RST,
    output_two_phase_offset:     SKEW_TWO_RST
  };

  // register fields and their next values
  logic [1:0]          loss_high_ff;
  logic [1:0]          nxt_loss_high;
  logic [1:0]          loss_low_ff;
  logic [1:0]          nxt_loss_low;
  logic [1:0]          offset_on_ff;
  logic [1:0]          nxt_offset_on;
  logic [7:0]          skew_one_ff;
  logic [7:0]          nxt_skew_one;
  logic [7:0]          skew_two_ff;
  logic [7:0]          nxt_skew_two;
  logic [7:0]          nxt_reg_rd_data;
  logic [7:0]          loss_high_view;
  logic [7:0]          mon_low_view;
  cmsr_pkg::cmsr_cfg_t nxt_cfg;

  // one strobe per register, decoded once and shared
  logic                wr_loss_high;
  logic                wr_mon_low;
  logic                wr_skew_one;
  logic                wr_skew_two;

  logic                rd_loss_high;
  logic                rd_mon_low;
  logic                rd_skew_one;
  logic                rd_skew_two;
  logic                rd_unmapped;

  // write data picked apart per input by the decode loop
  wire  logic [1:0]    wr_loss_high_bits;
  wire  logic [1:0]    wr_loss_low_bits;
  wire  logic [1:0]    wr_offset_bits;

  // loss decode results: a three-bit slice and a flag per input
  wire  logic [5:0]    loss_mode_bits;
  wire  logic [1:0]    loss_code_bad;

  // write strobes
  always_comb begin
    wr_loss_high = 1'b0;
    wr_mon_low   = 1'b0;
    wr_skew_one  = 1'b0;
    wr_skew_two  = 1'b0;
    if (reg_wr_en) begin
      case (reg_addr)
        `CMSR_LOSS_HIGH_ADDR: wr_loss_high = 1'b1;
        `CMSR_MON_LOW_ADDR:   wr_mon_low   = 1'b1;
        `CMSR_SKEW_ONE_ADDR:  wr_skew_one  = 1'b1;
        `CMSR_SKEW_TWO_ADDR:  wr_skew_two  = 1'b1;
        // writes elsewhere belong to other banks and are ignored here
        default:              wr_loss_high = 1'b0;
      endcase
    end
  end

  // read strobes: an unmapped read still answers, with zero
  always_comb begin
    rd_loss_high = 1'b0;
    rd_mon_low   = 1'b0;
    rd_skew_one  = 1'b0;
    rd_skew_two  = 1'b0;
    rd_unmapped  = 1'b0;
    if (reg_rd_en) begin
      case (reg_addr)
        `CMSR_LOSS_HIGH_ADDR: rd_loss_high = 1'b1;
        `CMSR_MON_LOW_ADDR:   rd_mon_low   = 1'b1;
        `CMSR_SKEW_ONE_ADDR:  rd_skew_one  = 1'b1;
        `CMSR_SKEW_TWO_ADDR:  rd_skew_two  = 1'b1;
        default:              rd_unmapped  = 1'b1;
      endcase
    end
  end

  // register storage: only the documented fields have flops, so
  // reserved bits have nowhere to land
  always_comb begin
    nxt_loss_high = loss_high_ff;
    nxt_loss_low  = loss_low_ff;
    nxt_offset_on = offset_on_ff;
    nxt_skew_one  = skew_one_ff;
    nxt_skew_two  = skew_two_ff;
    if (wr_loss_high) begin
      nxt_loss_high = wr_loss_high_bits;
    end
    if (wr_mon_low) begin
      nxt_loss_low  = wr_loss_low_bits;
      nxt_offset_on = wr_offset_bits;
    end
    if (wr_skew_one) begin
      nxt_skew_one = reg_wr_data;
    end
    if (wr_skew_two) begin
      nxt_skew_two = reg_wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      loss_high_ff <= LOSS_HIGH_RST_F;
      loss_low_ff  <= LOSS_LOW_RST_F;
      offset_on_ff <= OFFSET_RST_F;
      skew_one_ff  <= `CMSR_SKEW_ONE_RESET;
      skew_two_ff  <= `CMSR_SKEW_TWO_RESET;
    end else begin
      loss_high_ff <= nxt_loss_high;
      loss_low_ff  <= nxt_loss_low;
      offset_on_ff <= nxt_offset_on;
      skew_one_ff  <= nxt_skew_one;
      skew_two_ff  <= nxt_skew_two;
    end
  end

  // read-back: reserved bits are constants, so no write can move them
  always_comb begin
    loss_high_view = `CMSR_LOSS_HIGH_RSVD;
    loss_high_view[`CMSR_HI_LOSS_ONE_BIT] = loss_high_ff[0];
    loss_high_view[`CMSR_HI_LOSS_TWO_BIT] = loss_high_ff[1];
    mon_low_view = `CMSR_MON_LOW_RSVD;
    mon_low_view[`CMSR_LO_LOSS_ONE_BIT]   = loss_low_ff[0];
    mon_low_view[`CMSR_LO_LOSS_TWO_BIT]   = loss_low_ff[1];
    mon_low_view[`CMSR_LO_OFFSET_ONE_BIT] = offset_on_ff[0];
    mon_low_view[`CMSR_LO_OFFSET_TWO_BIT] = offset_on_ff[1];
  end

  // read mux: a read and a write of one address in one cycle return the
  // old value; the flop keeps its value between reads
  always_comb begin
    nxt_reg_rd_data = reg_rd_data_ff;
    if (rd_unmapped) begin
      nxt_reg_rd_data = 8'h00;
    end
    if (rd_loss_high) begin
      nxt_reg_rd_data = loss_high_view;
    end
    if (rd_mon_low) begin
      nxt_reg_rd_data = mon_low_view;
    end
    if (rd_skew_one) begin
      nxt_reg_rd_data = skew_one_ff;
    end
    if (rd_skew_two) begin
      nxt_reg_rd_data = skew_two_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd_data_ff <= 8'h00;
    end else begin
      reg_rd_data_ff <= nxt_reg_rd_data;
    end
  end

  // per-input handling of the split loss select fields; only the field
  // positions differ between the inputs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_input
      localparam int HI_POS  = (gi == 0) ? `CMSR_HI_LOSS_ONE_BIT
                                         : `CMSR_HI_LOSS_TWO_BIT;
      localparam int LO_POS  = (gi == 0) ? `CMSR_LO_LOSS_ONE_BIT
                                         : `CMSR_LO_LOSS_TWO_BIT;
      localparam int OFS_POS = (gi == 0) ? `CMSR_LO_OFFSET_ONE_BIT
                                         : `CMSR_LO_OFFSET_TWO_BIT;

      logic [1:0]                code;
      cmsr_pkg::cmsr_loss_mode_t mode;
      logic                      bad;

      // write data picked apart here, so each split field is joined once
      assign wr_loss_high_bits[gi] = reg_wr_data[HI_POS];
      assign wr_loss_low_bits[gi]  = reg_wr_data[LO_POS];
      assign wr_offset_bits[gi]    = reg_wr_data[OFS_POS];

      always_comb begin
        code = {loss_high_ff[gi], loss_low_ff[gi]};
        bad  = 1'b0;
        case (code)
          `CMSR_LOSS_CODE_OFF: begin
            mode = cmsr_pkg::CMSR_LOSS_OFF;
          end
          `CMSR_LOSS_CODE_SLOW: begin
            mode = cmsr_pkg::CMSR_LOSS_SLOW;
          end
          `CMSR_LOSS_CODE_NORMAL: begin
            mode = cmsr_pkg::CMSR_LOSS_NORMAL;
          end
          // the reserved code keeps the monitor quiet rather than guessing
          default: begin
            mode = cmsr_pkg::CMSR_LOSS_OFF;
            bad  = 1'b1;
          end
        endcase
      end

      assign loss_mode_bits[gi*3 +: 3] = mode;
      assign loss_code_bad[gi]         = bad;
    end
  endgenerate

  // settings: decoded selects first
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cfg.input_one_loss_mode =
      cmsr_pkg::cmsr_loss_mode_t'(loss_mode_bits[2:0]);
    nxt_cfg.input_two_loss_mode =
      cmsr_pkg::cmsr_loss_mode_t'(loss_mode_bits[5:3]);
    nxt_cfg.input_one_loss_code_bad     = loss_code_bad[0];
    nxt_cfg.input_two_loss_code_bad     = loss_code_bad[1];

    // enables and offsets pass straight through
    nxt_cfg.input_one_offset_monitor_on = offset_on_ff[0];
    nxt_cfg.input_two_offset_monitor_on = offset_on_ff[1];
    nxt_cfg.output_one_phase_offset     = skew_one_ff;
    nxt_cfg.output_two_phase_offset     = skew_two_ff;
  end

  // settings lag the register by one cycle so every output is a flop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

endmodule

`default_nettype wire

// >>> verif/cmsr_regs_asserts.sv
/*
  concurrent checks on the monitor enable and skew register bank.
  bound to cmsr_regs and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cmsr_regs_asserts (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                reset_n,
  // register port
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr_en,
  input wire logic [7:0]          reg_wr_data,
  input wire logic                reg_rd_en,
  input wire logic [7:0]          reg_rd_data_ff,
  // decoded settings
  input wire cmsr_pkg::cmsr_cfg_t cfg_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_hi_rsvd_read: assert property (
    reg_rd_en && reg_addr == 8'h8a |=> reg_rd_data_ff[7:2] == 6'h00)
    else $error("reserved bits of 0x8a changed");
  a_lo_rsvd_read: assert property (
    reg_rd_en && reg_addr == 8'h8b |=> reg_rd_data_ff[7:6] == 2'h3
      && reg_rd_data_ff[3:2] == 2'h3) else $error("reserved bits of 0x8b");
  a_skew_one_back: assert property (
    reg_wr_en && reg_addr == 8'h8e ##1 !reg_wr_en ##1 reg_rd_en
      && reg_addr == 8'h8e |=> reg_rd_data_ff == $past(reg_wr_data, 3))
    else $error("skew one read back differs");
  a_skew_two_back: assert property (
    reg_wr_en && reg_addr == 8'h8f ##1 !reg_wr_en ##1 reg_rd_en
      && reg_addr == 8'h8f |=> reg_rd_data_ff == $past(reg_wr_data, 3))
    else $error("skew two read back differs");
  a_offset_mon_cfg: assert property (
    reg_wr_en && reg_addr == 8'h8b ##1 !reg_wr_en [*2] |=>
      {cfg_ff.input_two_offset_monitor_on, cfg_ff.input_one_offset_monitor_on}
      == $past(reg_wr_data[1:0], 3)) else $error("offset enables wrong");
  a_reset_cfg_vals: assert property (
    $rose(reset_n) |-> cfg_ff.input_one_offset_monitor_on
      && cfg_ff.input_two_offset_monitor_on && cfg_ff.output_one_phase_offset
      == 8'sh00 && cfg_ff.output_two_phase_offset == 8'sh00)
    else $error("settings not at reset values");
  a_bad_code_off: assert property (
    cfg_ff.input_one_loss_code_bad || cfg_ff.input_two_loss_code_bad |->
      (!cfg_ff.input_one_loss_code_bad || cfg_ff.input_one_loss_mode
      == cmsr_pkg::CMSR_LOSS_OFF) && (!cfg_ff.input_two_loss_code_bad
      || cfg_ff.input_two_loss_mode == cmsr_pkg::CMSR_LOSS_OFF))
    else $error("reserved loss code not off");
  a_mode_one_hot: assert property (
    $onehot(cfg_ff.input_one_loss_mode) && $onehot(cfg_ff.input_two_loss_mode))
    else $error("loss mode not one-hot");
endmodule
bind cmsr_regs cmsr_regs_asserts chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data_ff(reg_rd_data_ff), .cfg_ff(cfg_ff));
`default_nettype wire

// >>> verif/cmsr_regs_tb.sv
/*
  self-checking bench for cmsr_regs: reset values, loss codes, random traffic.
  assumes the checker is bound by its own file; inputs move at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module cmsr_regs_tb;
  logic                ref_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic [7:0]          addr = 8'h00;
  logic [7:0]          wdata = 8'h00;
  logic [7:0]          rdata;
  cmsr_pkg::cmsr_cfg_t cfg;
  logic [7:0]          mdl [4];
  int                  n_fail = 0;
  int                  comparisons = 0;
  cmsr_regs uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(addr),
    .reg_wr_en(wr), .reg_wr_data(wdata), .reg_rd_en(rd),
    .reg_rd_data_ff(rdata), .cfg_ff(cfg));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // an idle cycle between strobes keeps each strobe to one change per step
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    @(negedge ref_clk);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
    chk("read data", e, rdata);
  endtask
  function automatic logic [7:0] wmask(logic [7:0] a, logic [7:0] d);
    if (a == 8'h8a) return d & 8'h03;
    if (a == 8'h8b) return (d & 8'h33) | 8'hcc;
    return d;
  endfunction
  function automatic logic [7:0] mode(logic [1:0] c);
    return (c == 2'h3) ? 8'h04 : (c == 2'h2) ? 8'h02 : 8'h01;
  endfunction
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(32'h2fe167fc));
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    rd_reg(8'h8b, 8'hff);
    rd_reg(8'h8e, 8'h00);
    rd_reg(8'h8f, 8'h00);
    rd_reg(8'h8a, 8'h03);
    mdl = '{8'h03, 8'hff, 8'h00, 8'h00};
    // every select code on both inputs, the reserved one included
    for (int c = 0; c < 16; c++) begin
      wr_reg(8'h8a, {6'h00, c[3], c[1]});
      wr_reg(8'h8b, {2'h0, c[2], c[0], 4'h3});
      repeat (2) @(negedge ref_clk);
      chk("mode one", mode(c[1:0]), {5'h00, cfg.input_one_loss_mode});
      chk("mode two", mode(c[3:2]), {5'h00, cfg.input_two_loss_mode});
      chk("code bad", {6'h00, c[3:2] == 2'h1, c[1:0] == 2'h1}, {6'h00,
        cfg.input_two_loss_code_bad, cfg.input_one_loss_code_bad});
    end
    for (int i = 0; i < 60; i++) begin
      a = 8'h8a + 8'($urandom_range(0, 5));
      d = 8'($urandom);
      wr_reg(a, d);
      if (a != 8'h8c && a != 8'h8d) mdl[{a[2], a[0]}] = wmask(a, d);
      rd_reg(a, (a == 8'h8c || a == 8'h8d) ? 8'h00 : mdl[{a[2], a[0]}]);
      chk("skew one", mdl[2], cfg.output_one_phase_offset);
      chk("skew two", mdl[3], cfg.output_two_phase_offset);
      chk("offset on", {6'h00, mdl[1][1:0]}, {6'h00,
        cfg.input_two_offset_monitor_on, cfg.input_one_offset_monitor_on});
    end
    conclude();
  end
endmodule
`default_nettype wire
